// [verilog/sfd_cfg.svh]
// sfd_cfg.svh: offsets, field positions, reset values and table constants of the synthesizer field decoder.
// assumes: included by bare name by the package and every design file that needs the numbers.
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH

// register offsets on the plain register port
`define SFD_ADDR_W 8
`define SFD_OFS_FEATURE 8'h00
`define SFD_OFS_FUNCTION 8'h04
`define SFD_OFS_STATUS 8'h08

`define SFD_FEATURE_RST 32'h0000_0000
`define SFD_FUNCTION_RST 32'h0000_0000

// misc_feature_config fields
`define SFD_MODE_MSB 1
`define SFD_MODE_LSB 0
`define SFD_POWER_DOWN_BIT_BIT 2
`define SFD_XO_BIT 3
`define SFD_PUMP_MSB 8
`define SFD_PUMP_LSB 4
`define SFD_FPUMP_MSB 13
`define SFD_FPUMP_LSB 9
`define SFD_FRES_A_MSB 16
`define SFD_FRES_A_LSB 14
`define SFD_FRES_B_MSB 19
`define SFD_FRES_B_LSB 17

// misc_function_config fields
`define SFD_REF_MSB 7
`define SFD_REF_LSB 0
`define SFD_DIV_MSB 13
`define SFD_DIV_LSB 8
`define SFD_NRES_A_MSB 16
`define SFD_NRES_A_LSB 14
`define SFD_NRES_B_MSB 19
`define SFD_NRES_B_LSB 17
`define SFD_CAP_A_MSB 23
`define SFD_CAP_A_LSB 20
`define SFD_CAP_B_MSB 27
`define SFD_CAP_B_LSB 24

// status bits
`define SFD_ST_FAST 0
`define SFD_ST_POWER_DOWN_BIT 1
`define SFD_ST_RES_A_BAD 2
`define SFD_ST_RES_B_BAD 3
`define SFD_ST_REF_BAD 4
`define SFD_ST_DIV_BAD 5
`define SFD_ST_TEST_MODE 6
`define SFD_ST_CAP_A_TOP 7
`define SFD_ST_W 8

// resistor codes and their settings in ohm
`define SFD_RES_LOW 3'h0
`define SFD_RES_1K 3'h1
`define SFD_RES_2K 3'h2
`define SFD_RES_4K 3'h3
`define SFD_RES_16K 3'h4
`define SFD_OHM_LOW 16'h00c8
`define SFD_OHM_1K 16'h03e8
`define SFD_OHM_2K 16'h07d0
`define SFD_OHM_4K 16'h0fa0
`define SFD_OHM_16K 16'h3e80

// charge pump unit current in uA
`define SFD_PUMP_UNIT_UA 12'h064

// capacitor weights in pF and the cap a top code
`define SFD_CAP_A_FINE 8'h01
`define SFD_CAP_A_STEP 8'h05
`define SFD_CAP_A_TOP_CODE 4'hf
`define SFD_CAP_A_TOP_PF 8'h24
`define SFD_CAP_B_W0 8'h05
`define SFD_CAP_B_W1 8'h14
`define SFD_CAP_B_W2 8'h28
`define SFD_CAP_B_W3 8'h64

// divider and reference codes
`define SFD_DIV_ILLEGAL 6'h00
`define SFD_DIV_BYPASS 6'h01
`define SFD_REF_ILLEGAL 8'h00

`endif

// [verilog/sfd_pkg.sv]
// sfd_pkg: types shared by the synthesizer field decoder files.
// assumes: sfd_cfg.svh holds every number; this package only gives them shape.
`include "sfd_cfg.svh"

package sfd_pkg;

    typedef enum logic [1:0] {
        SFD_MODE_FULL,
        SFD_MODE_EXT_VCO,
        SFD_MODE_DIV_ONLY,
        SFD_MODE_TEST
    } sfd_mode_t;

    // decoded loop filter and charge pump settings
    typedef struct packed {
        logic [15:0] res_a_ohm;
        logic res_a_valid;
        logic [15:0] res_b_ohm;
        logic res_b_valid;
        logic [11:0] pump_ua;
        logic [7:0] cap_a_pf;
        logic [7:0] cap_b_pf;
        logic cap_valid;
    } sfd_loop_t;

    // block enables
    typedef struct packed {
        logic div_en;
        logic pll_en;
        logic vco_en;
        logic powered_down;
        logic crystal_en;
    } sfd_enable_t;

    // register port request
    typedef struct packed {
        logic [`SFD_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sfd_req_t;

endpackage : sfd_pkg

// [verilog/sfd_vco_div.sv]
// sfd_vco_div: vco output divider counting synchronised vco edges.
// assumes: vco_tick is a one-cycle event on clk; resync comes from a register write.
`include "sfd_cfg.svh"

module sfd_vco_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic vco_tick,
    input wire logic [5:0] div_value,
    input wire logic run,
    input wire logic resync,
    output logic div_out
);
    logic [5:0] cnt_q;

    // resync restarts the count so the output phase is known again
    always_ff @(posedge clk) begin
        if (!rst_n || resync || !run) begin
            cnt_q <= 6'h00;
        end else if (vco_tick) begin
            if (cnt_q >= div_value - 6'h01) begin
                cnt_q <= 6'h00;
            end else begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    // bypass passes every vco edge, otherwise one pulse per div_value edges
    always_ff @(posedge clk) begin
        if (!rst_n || resync || !run) begin
            div_out <= 1'b0;
        end else if (div_value == `SFD_DIV_BYPASS) begin
            div_out <= vco_tick;
        end else begin
            div_out <= vco_tick && (cnt_q == 6'h00);
        end
    end

endmodule : sfd_vco_div

// [verilog/sfd_field_decode.sv]
// sfd_field_decode: register bank and field decoder of the frequency synthesizer configuration.
// assumes: one 100 MHz clock, fastlock_active from the fastlock timer on the same clock,
// external_vco_input a raw pin that is synchronised here.
//
// Summary of operation
// - fastlock active: fast_res_a_code picks 200 ohm, 1k, 2k, 4k, 16k; 5-7 reserved.
// - fastlock active: fast_res_b_code uses the same resistor mapping; 5-7 reserved.
// - fastlock active: pump current is (fast_pump_gain+1) times 100 uA.
// - every write to misc_function_config resynchronises the vco output divider.
// - divider value 2 to 63 divides, 1 bypasses in full-chip mode (flagged as illegal in other modes), 0 is illegal.
// - full-chip, no fastlock: normal resistor codes with the same mapping apply.
// - full-chip: filter_cap_a_code decodes 0,1,5,6,...,35 pF; code 15 taken as 36.
// - full-chip: filter_cap_b_code decodes 0,5,20,25,...,160,165 pF.
// - mode 0 all on, 1 vco off, 2 divider only, 3 test all on.
// - power_down_bit powers all functions down, keeping register contents.
// - crystal_select_bit turns the reference input into a crystal oscillator.
// - outside fastlock pump current is (pump_gain_code+1) times 100 uA.
// - fastlock switches pump and resistors to fast codes, reverting when it ends.
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "sfd_cfg.svh"

module sfd_field_decode (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`SFD_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic fastlock_active,
    input wire logic external_vco_input,
    output sfd_pkg::sfd_loop_t loop_q,
    output sfd_pkg::sfd_enable_t enable_q,
    output sfd_pkg::sfd_mode_t mode_q,
    output logic [7:0] ref_mhz_q,
    output logic [5:0] div_value_q,
    output logic div_bypass_q,
    output logic div_valid_q,
    output logic resync_q,
    output logic vco_div_out
);
    logic [31:0] feature_q;
    logic [31:0] function_q;
    logic [31:0] rdata_q;
    logic vco_meta_q;
    logic vco_sync_q;
    logic vco_prev_q;
    logic vco_tick;
    logic [`SFD_ST_W-1:0] status;
    sfd_pkg::sfd_req_t req;

    // field views
    logic [2:0] fres_a;
    logic [2:0] fres_b;
    logic [4:0] fpump;
    logic [4:0] npump;
    logic [2:0] nres_a;
    logic [2:0] nres_b;
    logic [3:0] cap_a;
    logic [3:0] cap_b;
    logic [5:0] div_code;
    logic [7:0] ref_code;
    sfd_pkg::sfd_mode_t mode;
    logic full_mode;

    // selected settings before the output flops
    logic [2:0] res_a_sel;
    logic [2:0] res_b_sel;
    logic [4:0] pump_sel;
    logic [15:0] res_a_ohm;
    logic [15:0] res_b_ohm;
    logic res_a_ok;
    logic res_b_ok;
    logic [7:0] cap_a_pf;
    logic [7:0] cap_b_pf;
    logic [11:0] pump_ua;
    logic div_ok;
    sfd_pkg::sfd_enable_t enable_d;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    assign fres_a = feature_q[`SFD_FRES_A_MSB:`SFD_FRES_A_LSB];
    assign fres_b = feature_q[`SFD_FRES_B_MSB:`SFD_FRES_B_LSB];
    assign fpump = feature_q[`SFD_FPUMP_MSB:`SFD_FPUMP_LSB];
    assign npump = feature_q[`SFD_PUMP_MSB:`SFD_PUMP_LSB];
    assign mode = sfd_pkg::sfd_mode_t'(feature_q[`SFD_MODE_MSB:`SFD_MODE_LSB]);
    assign nres_a = function_q[`SFD_NRES_A_MSB:`SFD_NRES_A_LSB];
    assign nres_b = function_q[`SFD_NRES_B_MSB:`SFD_NRES_B_LSB];
    assign cap_a = function_q[`SFD_CAP_A_MSB:`SFD_CAP_A_LSB];
    assign cap_b = function_q[`SFD_CAP_B_MSB:`SFD_CAP_B_LSB];
    assign div_code = function_q[`SFD_DIV_MSB:`SFD_DIV_LSB];
    assign ref_code = function_q[`SFD_REF_MSB:`SFD_REF_LSB];
    assign full_mode = (mode == sfd_pkg::SFD_MODE_FULL);

    // one resistor table for all four codes; reserved codes give no setting
    function automatic logic [16:0] res_decode(input logic [2:0] code);
        logic [16:0] r;
        r = {1'b0, 16'h0000};
        case (code)
            `SFD_RES_LOW: r = {1'b1, `SFD_OHM_LOW};
            `SFD_RES_1K: r = {1'b1, `SFD_OHM_1K};
            `SFD_RES_2K: r = {1'b1, `SFD_OHM_2K};
            `SFD_RES_4K: r = {1'b1, `SFD_OHM_4K};
            `SFD_RES_16K: r = {1'b1, `SFD_OHM_16K};
            default: r = {1'b0, 16'h0000};
        endcase
        return r;
    endfunction : res_decode

    // register writes; both words are write-only from software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            feature_q <= `SFD_FEATURE_RST;
        end else if (req.wr && req.addr == `SFD_OFS_FEATURE) begin
            feature_q <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            function_q <= `SFD_FUNCTION_RST;
        end else if (req.wr && req.addr == `SFD_OFS_FUNCTION) begin
            function_q <= req.wdata;
        end
    end

    // an identical rewrite still resyncs: the pulse does not look at the data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resync_q <= 1'b0;
        end else begin
            resync_q <= req.wr && (req.addr == `SFD_OFS_FUNCTION);
        end
    end

    // status shows live decoder state; config words read as zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.rd && req.addr == `SFD_OFS_STATUS) begin
            rdata_q <= {{(32 - `SFD_ST_W){1'b0}}, status};
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    // vco presence comes from a pin: two flops before the edge detector
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vco_meta_q <= 1'b0;
            vco_sync_q <= 1'b0;
            vco_prev_q <= 1'b0;
        end else begin
            vco_meta_q <= external_vco_input;
            vco_sync_q <= vco_meta_q;
            vco_prev_q <= vco_sync_q;
        end
    end

    assign vco_tick = vco_sync_q && !vco_prev_q;

    // fastlock selects the fast codes, otherwise the normal ones
    always_comb begin
        if (fastlock_active) begin
            res_a_sel = fres_a;
            res_b_sel = fres_b;
            pump_sel = fpump;
        end else begin
            res_a_sel = nres_a;
            res_b_sel = nres_b;
            pump_sel = npump;
        end
    end

    // fast resistor codes act whenever fastlock runs; normal ones only in full-chip mode
    always_comb begin
        {res_a_ok, res_a_ohm} = res_decode(res_a_sel);
        {res_b_ok, res_b_ohm} = res_decode(res_b_sel);
        if (!fastlock_active && !full_mode) begin
            res_a_ok = 1'b0;
            res_a_ohm = 16'h0000;
            res_b_ok = 1'b0;
            res_b_ohm = 16'h0000;
        end
    end

    // (n+1) units of 100 uA, 32 units at most so 12 bits suffice
    assign pump_ua = 12'(({7'h00, pump_sel} + 12'h001) * `SFD_PUMP_UNIT_UA);

    // cap a: 5 pF steps plus a 1 pF fine bit; the top code is taken as 36 pF
    always_comb begin
        if (cap_a == `SFD_CAP_A_TOP_CODE) begin
            cap_a_pf = `SFD_CAP_A_TOP_PF;
        end else begin
            cap_a_pf = (cap_a[0] ? `SFD_CAP_A_FINE : 8'h00)
                + 8'({5'h00, cap_a[3:1]} * `SFD_CAP_A_STEP);
        end
    end

    // cap b: binary weighted 5, 20, 40 and 100 pF
    always_comb begin
        cap_b_pf = (cap_b[0] ? `SFD_CAP_B_W0 : 8'h00)
            + (cap_b[1] ? `SFD_CAP_B_W1 : 8'h00)
            + (cap_b[2] ? `SFD_CAP_B_W2 : 8'h00)
            + (cap_b[3] ? `SFD_CAP_B_W3 : 8'h00);
    end

    // bypass outside full-chip mode is a host fault; it is flagged, not obeyed
    assign div_ok = (div_code != `SFD_DIV_ILLEGAL)
        && !(div_code == `SFD_DIV_BYPASS && !full_mode);

    // mode enables, all forced off by power-down
    always_comb begin
        enable_d = '0;
        case (mode)
            sfd_pkg::SFD_MODE_FULL: begin
                enable_d.div_en = 1'b1;
                enable_d.pll_en = 1'b1;
                enable_d.vco_en = 1'b1;
            end
            sfd_pkg::SFD_MODE_EXT_VCO: begin
                enable_d.div_en = 1'b1;
                enable_d.pll_en = 1'b1;
            end
            sfd_pkg::SFD_MODE_DIV_ONLY: begin
                enable_d.div_en = 1'b1;
            end
            sfd_pkg::SFD_MODE_TEST: begin
                enable_d.div_en = 1'b1;
                enable_d.pll_en = 1'b1;
                enable_d.vco_en = 1'b1;
            end
            default: begin
                enable_d.div_en = 1'b0;
            end
        endcase
        if (feature_q[`SFD_POWER_DOWN_BIT_BIT]) begin
            enable_d.div_en = 1'b0;
            enable_d.pll_en = 1'b0;
            enable_d.vco_en = 1'b0;
            enable_d.powered_down = 1'b1;
        end
        enable_d.crystal_en = feature_q[`SFD_XO_BIT] && !feature_q[`SFD_POWER_DOWN_BIT_BIT];
    end

    // settings leave through flops; power-down leaves the register words untouched
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loop_q <= '0;
        end else begin
            loop_q.res_a_ohm <= res_a_ohm;
            loop_q.res_a_valid <= res_a_ok;
            loop_q.res_b_ohm <= res_b_ohm;
            loop_q.res_b_valid <= res_b_ok;
            loop_q.pump_ua <= pump_ua;
            loop_q.cap_a_pf <= full_mode ? cap_a_pf : 8'h00;
            loop_q.cap_b_pf <= full_mode ? cap_b_pf : 8'h00;
            loop_q.cap_valid <= full_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_q <= '0;
            mode_q <= sfd_pkg::SFD_MODE_FULL;
        end else begin
            enable_q <= enable_d;
            mode_q <= mode;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_mhz_q <= `SFD_REF_ILLEGAL;
            div_value_q <= `SFD_DIV_ILLEGAL;
            div_bypass_q <= 1'b0;
            div_valid_q <= 1'b0;
        end else begin
            ref_mhz_q <= ref_code;
            div_value_q <= div_code;
            div_bypass_q <= div_ok && (div_code == `SFD_DIV_BYPASS);
            div_valid_q <= div_ok;
        end
    end

    // fault and state view for software
    always_comb begin
        status = '0;
        status[`SFD_ST_FAST] = fastlock_active;
        status[`SFD_ST_POWER_DOWN_BIT] = feature_q[`SFD_POWER_DOWN_BIT_BIT];
        status[`SFD_ST_RES_A_BAD] = !res_a_ok;
        status[`SFD_ST_RES_B_BAD] = !res_b_ok;
        status[`SFD_ST_REF_BAD] = (ref_code == `SFD_REF_ILLEGAL);
        status[`SFD_ST_DIV_BAD] = !div_ok;
        status[`SFD_ST_TEST_MODE] = (mode == sfd_pkg::SFD_MODE_TEST);
        status[`SFD_ST_CAP_A_TOP] = (cap_a == `SFD_CAP_A_TOP_CODE);
    end

    // divider runs only with a legal value and the divider enabled
    sfd_vco_div u_vco_div (
        .clk(clk),
        .rst_n(rst_n),
        .vco_tick(vco_tick),
        .div_value(div_code),
        .run(div_ok && enable_d.div_en),
        .resync(resync_q),
        .div_out(vco_div_out)
    );

endmodule : sfd_field_decode

// [test/sfd_field_decode_monitor.sv]
// sfd_field_decode_monitor: port checks for the field decoder.
// assumes: bound to sfd_field_decode; the feature word is shadowed from the write strobe.
`include "sfd_cfg.svh"

module sfd_field_decode_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`SFD_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic fastlock_active,
    input wire logic external_vco_input,
    input wire sfd_pkg::sfd_loop_t loop_q,
    input wire sfd_pkg::sfd_enable_t enable_q,
    input wire sfd_pkg::sfd_mode_t mode_q,
    input wire logic [7:0] ref_mhz_q,
    input wire logic [5:0] div_value_q,
    input wire logic div_bypass_q,
    input wire logic div_valid_q,
    input wire logic resync_q,
    input wire logic vco_div_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] feat_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            feat_q <= `SFD_FEATURE_RST;
        end else if (reg_wr && reg_addr == `SFD_OFS_FEATURE) begin
            feat_q <= reg_wdata;
        end
    end

    // decoded outputs follow the stored word one edge later, hence the past() terms
    property p_resync;
        reg_wr && reg_addr == `SFD_OFS_FUNCTION |=> resync_q;
    endproperty
    a_resync: assert property (p_resync) else $error("missing resync pulse");
    property p_resync_src;
        resync_q |-> $past(reg_wr) && $past(reg_addr) == `SFD_OFS_FUNCTION;
    endproperty
    a_resync_src: assert property (p_resync_src) else $error("stray resync pulse");
    property p_pump_fast;
        $past(rst_n) && $past(fastlock_active) |-> loop_q.pump_ua == ({7'h0, $past(feat_q[13:9])} + 12'h001) * 12'h064;
    endproperty
    a_pump_fast: assert property (p_pump_fast) else $error("fast pump current wrong");
    property p_res_fast;
        $past(rst_n) && $past(fastlock_active) && $past(feat_q[16:14]) == 3'h4 |->
            loop_q.res_a_ohm == 16'h3e80 && loop_q.res_a_valid;
    endproperty
    a_res_fast: assert property (p_res_fast) else $error("fast resistor wrong");
    property p_power_down_bit;
        $past(rst_n) && $past(feat_q[2]) |-> enable_q.powered_down && !enable_q.div_en && !enable_q.vco_en;
    endproperty
    a_power_down_bit: assert property (p_power_down_bit) else $error("power down not applied");
    property p_ext;
        $past(rst_n) && $past(feat_q[2:0]) == 3'h1 |->
            mode_q == sfd_pkg::SFD_MODE_EXT_VCO && enable_q.pll_en && !enable_q.vco_en;
    endproperty
    a_ext: assert property (p_ext) else $error("external vco mode enables wrong");
    property p_crystal;
        $past(rst_n) |-> enable_q.crystal_en == ($past(feat_q[3]) && !$past(feat_q[2]));
    endproperty
    a_crystal: assert property (p_crystal) else $error("crystal enable wrong");
    property p_div_legal;
        div_valid_q |-> div_value_q != 6'h00 && (div_value_q != 6'h01 || mode_q == sfd_pkg::SFD_MODE_FULL);
    endproperty
    a_div_legal: assert property (p_div_legal) else $error("illegal divider marked valid");

    c_fast: cover property (fastlock_active && loop_q.res_a_valid);
    c_bypass: cover property (div_bypass_q && vco_div_out);
    c_rewrite: cover property (resync_q ##2 resync_q);
endmodule : sfd_field_decode_monitor

// [test/sfd_host_model.sv]
// sfd_host_model: host writing and reading config words on the register port.
// assumes: shares clk with the decoder; never asks it to wait.
`include "sfd_cfg.svh"

module sfd_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd

    // ref code 0 and bypass outside full-chip mode are made legal unless bad asks for a refusal on purpose
    task automatic cfg(input logic [31:0] ft, input logic [31:0] fn, input logic bad,
                       output logic [31:0] fto, output logic [31:0] fno);
        fto = ft;
        fno = fn;
        if (!bad && fno[7:0] == 8'h00) fno[7:0] = 8'h01;
        if (!bad && fto[1:0] != 2'h0 && fno[13:8] == 6'h01) fno[13:8] = 6'h02;
        wr(`SFD_OFS_FEATURE, fto);
        wr(`SFD_OFS_FUNCTION, fno);
        // divide 4 and 5 need a repeat write once the vco runs, also after power-down
        if (fno[13:8] == 6'h04 || fno[13:8] == 6'h05) wr(`SFD_OFS_FUNCTION, fno);
    endtask : cfg
endmodule : sfd_host_model

// [test/synth_config_field_decode_tb_top.sv]
// synth_config_field_decode_tb_top: self-checking bench of the field decoder.
// assumes: design files compiled first; the host model owns the register port.
`include "sfd_cfg.svh"

module synth_config_field_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic fastlock_active;
    logic external_vco_input = 1'b0;
    sfd_pkg::sfd_loop_t loop_q;
    sfd_pkg::sfd_enable_t enable_q;
    sfd_pkg::sfd_mode_t mode_q;
    logic [7:0] ref_mhz_q;
    logic [5:0] div_value_q;
    logic div_bypass_q;
    logic div_valid_q;
    logic resync_q;
    logic vco_div_out;
    logic [1:0] ph = 2'h0;
    int pulses = 0;
    int fails;
    int cmp_count;
    int seed;

    sfd_field_decode dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fastlock_active(fastlock_active),
        .external_vco_input(external_vco_input), .loop_q(loop_q), .enable_q(enable_q), .mode_q(mode_q),
        .ref_mhz_q(ref_mhz_q), .div_value_q(div_value_q), .div_bypass_q(div_bypass_q),
        .div_valid_q(div_valid_q), .resync_q(resync_q), .vco_div_out(vco_div_out));
    sfd_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // vco stand-in: one rising edge every 4 clocks
    always @(posedge clk) begin
        ph <= ph + 2'h1;
        external_vco_input <= ph[1];
        if (vco_div_out === 1'b1) pulses <= pulses + 1;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    function automatic logic [16:0] res(input logic [2:0] c);
        case (c)
            3'h0: return {16'h00c8, 1'b1};
            3'h1: return {16'h03e8, 1'b1};
            3'h2: return {16'h07d0, 1'b1};
            3'h3: return {16'h0fa0, 1'b1};
            3'h4: return {16'h3e80, 1'b1};
            default: return 17'h0;
        endcase
    endfunction : res

    function automatic logic [62:0] exp_loop(input logic [31:0] ft, input logic [31:0] fn, input logic fl);
        logic full;
        logic [3:0] a;
        logic [3:0] b;
        logic [7:0] ca;
        logic [7:0] cb;
        logic [4:0] g;
        full = ft[1:0] == 2'h0;
        a = fn[23:20];
        b = fn[27:24];
        // top code of cap a reads as 36 pF, the printed 26 breaks the 5 pF pattern
        ca = (a == 4'hf) ? 8'h24 : {5'h0, a[3:1]} * 8'h05 + {7'h0, a[0]};
        cb = {7'h0, b[0]} * 8'h05 + {7'h0, b[1]} * 8'h14 + {7'h0, b[2]} * 8'h28 + {7'h0, b[3]} * 8'h64;
        g = fl ? ft[13:9] : ft[8:4];
        return {fl ? res(ft[16:14]) : full ? res(fn[16:14]) : 17'h0,
                fl ? res(ft[19:17]) : full ? res(fn[19:17]) : 17'h0,
                ({7'h0, g} + 12'h001) * 12'h064, full ? {ca, cb, 1'b1} : 17'h0};
    endfunction : exp_loop

    function automatic logic [4:0] exp_en(input logic [31:0] ft);
        return {!ft[2], !ft[2] && ft[1:0] != 2'h2, !ft[2] && ft[1] == ft[0], ft[2], !ft[2] && ft[3]};
    endfunction : exp_en

    // status view: cap top, test mode, divider bad, ref zero, resistor b/a not applied, power-down, fastlock
    function automatic logic [7:0] exp_st(input logic [31:0] ft, input logic [31:0] fn, input logic fl);
        logic [62:0] l;
        l = exp_loop(ft, fn, fl);
        return {fn[23:20] == 4'hf, ft[1:0] == 2'h3, fn[13:8] == 6'h0 || (fn[13:8] == 6'h1 && ft[1:0] != 2'h0),
                fn[7:0] == 8'h0, !l[29], !l[46], ft[2], fl};
    endfunction : exp_st

    task automatic try(input logic [31:0] ft0, input logic [31:0] fn0, input logic bad, input logic fl);
        logic [31:0] ft;
        logic [31:0] fn;
        logic [31:0] d;
        fastlock_active <= fl;
        host.cfg(ft0, fn0, bad, ft, fn);
        for (int k = 0; k < 2; k++) begin
            repeat (2) @(posedge clk);
            chk(64'(loop_q), 64'(exp_loop(ft, fn, fastlock_active)));
            chk(64'(enable_q), 64'(exp_en(ft)));
            chk(64'({mode_q, ref_mhz_q, div_value_q, div_valid_q, div_bypass_q}), 64'({ft[1:0], fn[7:0], fn[13:8],
                fn[13:8] != 6'h0 && (fn[13:8] != 6'h1 || ft[1:0] == 2'h0), fn[13:8] == 6'h1 && ft[1:0] == 2'h0}));
            host.rd(`SFD_OFS_STATUS, d);
            chk(64'(d), 64'(exp_st(ft, fn, fastlock_active)));
            fastlock_active <= !fastlock_active;
        end
    endtask : try

    task automatic vco(input logic [5:0] dv, input logic pd, input int exp);
        logic [31:0] ft;
        logic [31:0] fn;
        int p0;
        fastlock_active <= 1'b0;
        host.cfg({28'h0, 1'b0, pd, 2'h0}, {18'h0, dv, 8'h64}, 1'b0, ft, fn);
        repeat (40) @(posedge clk);
        p0 = pulses;
        repeat (20 * dv) @(posedge clk);
        chk(64'(pulses - p0), 64'(exp));
    endtask : vco

    initial begin
        logic [31:0] d;
        logic [31:0] ft;
        int dvs[6] = '{1, 2, 3, 4, 5, 63};
        seed = 90134;
        rst_n = 1'b0;
        fastlock_active = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        host.rd(`SFD_OFS_STATUS, d);
        chk(64'(d), 64'h30);
        host.wr(`SFD_OFS_STATUS, 32'hffff_ffff);
        host.wr(8'h0c, 32'hffff_ffff);
        host.rd(8'h0c, d);
        chk(64'(d), 64'h0);
        host.rd(`SFD_OFS_FEATURE, d);
        chk(64'(d), 64'h0);
        host.rd(`SFD_OFS_STATUS, d);
        chk(64'(d), 64'h30);
        $display("register access done");
        try(32'h0, 32'h0ff0_0164, 1'b0, 1'b0);
        try(32'h1, 32'h0ff0_0100, 1'b1, 1'b1);
        $display("corner decode done");
        for (int i = 0; i < 40; i++) begin
            ft = $random(seed);
            ft[1:0] = 2'(i);
            try(ft, $random(seed), 1'b0, 1'($random(seed)));
        end
        $display("random decode done");
        foreach (dvs[j]) vco(6'(dvs[j]), 1'b0, 5);
        vco(6'h04, 1'b1, 0);
        vco(6'h04, 1'b0, 5);
        $display("vco divider done");
        summarize();
    end

    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule : synth_config_field_decode_tb_top

bind sfd_field_decode sfd_field_decode_monitor u_mon (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fastlock_active(fastlock_active), .external_vco_input(external_vco_input), .loop_q(loop_q),
    .enable_q(enable_q), .mode_q(mode_q), .ref_mhz_q(ref_mhz_q), .div_value_q(div_value_q),
    .div_bypass_q(div_bypass_q), .div_valid_q(div_valid_q), .resync_q(resync_q), .vco_div_out(vco_div_out));
